/* hdl/pfs_defs.svh */
/*
  Constants for the pixel fail-safe supervisor: register offsets,
  field positions, reset values and the mode encodings.
  Assumes it is included by its bare name from every design file.
*/
// Summary of operation
// (RULE1) Any latched fault flag puts the device into a fail-safe mode.
// (RULE2) The host leaves fail-safe by reading the status register at 0x10.
// (RULE3) A dimming error or timeout alone selects the OTP fail-safe mode.
// (RULE4) On a timeout the switches take the fail-safe pattern from OTP.
// (RULE5) With OTP not programmed, a timeout turns every switch off.
// (RULE6) After the timeout clears, the switches keep their present state.
// (RULE7) A dimming error alone leaves the switch operation unchanged.
// (RULE8) A hardware fault selects the open fail-safe mode, switches off.
// (RULE9) When hardware faults clear, switches reload from register 0x00.
// (RULE10) Hardware faults outrank application faults, so open mode wins.
// (RULE11) After reset the OTP bits pick config, normal or no-CRC mode.
// (RULE12) An unprogrammed device starts in configuration mode.
// (RULE13) The host computes dimming values and then sends map-enable.
// (RULE14) The host polls all status flags and refreshes within the watchdog.
// (RULE15) A flag clears after a status read once its cause is gone.
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
`define PFS_ADDR_W        8
`define PFS_DATA_W        24
`define PFS_OFS_SWITCH    8'h00
`define PFS_OFS_STATUS    8'h10
`define PFS_SWITCH_RST    24'h000000

// ---------------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------------
`define PFS_BIT_THERM     0
`define PFS_BIT_PUMPUV    1
`define PFS_BIT_SUPLOW    2
`define PFS_BIT_DIMM      3
`define PFS_BIT_TIMEOUT   4
`define PFS_BIT_FS_OPEN   8
`define PFS_BIT_FS_OTP    9
`define PFS_OPM_LSB       12
`define PFS_NFLAGS        5
`define PFS_NSW           12

// ---------------------------------------------------------------------
// Operating-mode codes
// ---------------------------------------------------------------------
`define PFS_OPM_CONFIG    2'h0
`define PFS_OPM_NORMAL    2'h1
`define PFS_OPM_NOCRC     2'h2

`endif

/* hdl/pfs_flag_latch.sv */
/*
  One sticky fault flag with read-to-clear behaviour.
  Assumes fault is already synchronised to mclk.
*/
`timescale 1ns/1ps
`include "pfs_defs.svh"

module pfs_flag_latch (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic fault,
  input  wire logic rd_clr,
  output logic      flag
);

  logic flag_r;
  logic flag_nxt;

  // ---------------------------------------------------------------------
  // Set wins over clear; clear needs a read and a vanished cause
  // ---------------------------------------------------------------------
  always_comb begin
    flag_nxt = flag_r;
    if (fault)
      flag_nxt = 1'b1;
    else if (rd_clr)
      flag_nxt = 1'b0;                     // see (RULE15)
  end

  // Register the flag
  always_ff @(posedge mclk) begin
    if (rst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign flag = flag_r;

endmodule : pfs_flag_latch

/* hdl/pfs_failsafe_ctrl.sv */
/*
  Fail-safe supervisor for a twelve-switch pixel controller: fault flags,
  mode choice, switch drive and power-on operating mode.
  Assumes fault inputs and OTP bits are raw pins from other domains and
  that the serial front end supplies single-cycle register strobes.
*/
`timescale 1ns/1ps
`include "pfs_defs.svh"

package pfs_pkg;
  typedef enum logic [2:0] {
    PFS_ST_RUN  = 3'b001,
    PFS_ST_OPEN = 3'b010,
    PFS_ST_OTP  = 3'b100
  } pfs_state_e;
endpackage : pfs_pkg

module pfs_failsafe_ctrl #(
  parameter int NSW = `PFS_NSW
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [`PFS_ADDR_W-1:0] reg_addr,
  input  wire logic [`PFS_DATA_W-1:0] reg_wdata,
  output logic      [`PFS_DATA_W-1:0] reg_rdata,
  input  wire logic                   thermal_shutdown_flag,
  input  wire logic                   pump_cap_undervoltage_flag,
  input  wire logic                   supply_low_flag,
  input  wire logic                   dimming_error_flag,
  input  wire logic                   timeout_in,
  input  wire logic                   otp_programmed,
  input  wire logic [1:0]             otp_mode,
  input  wire logic [NSW-1:0]         otp_failsafe_sw,
  output logic      [NSW-1:0]         switch_on,
  output logic      [1:0]             op_mode,
  output logic                        failsafe_open,
  output logic                        failsafe_otp
);

  localparam int NF = `PFS_NFLAGS;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [NF-1:0]  flt_s1_r;
  logic [NF-1:0]  flt_s2_r;
  logic [NSW+2:0] otp_s1_r;
  logic [NSW+2:0] otp_s2_r;
  logic [NF-1:0]  flt_raw;

  assign flt_raw = {timeout_in, dimming_error_flag, supply_low_flag,
                    pump_cap_undervoltage_flag, thermal_shutdown_flag};

  // Two flops before any logic sees a pin
  always_ff @(posedge mclk) begin
    flt_s1_r <= flt_raw;
    flt_s2_r <= flt_s1_r;
    otp_s1_r <= {otp_programmed, otp_mode, otp_failsafe_sw};
    otp_s2_r <= otp_s1_r;
  end

  // ---------------------------------------------------------------------
  // Sticky fault flags
  // ---------------------------------------------------------------------
  logic [NF-1:0] flag;
  logic          stat_rd;

  assign stat_rd = reg_rd && (reg_addr == `PFS_OFS_STATUS); // see (RULE2)

  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_flag
      pfs_flag_latch u_flag (
        .mclk   (mclk),
        .rst    (rst),
        .fault  (flt_s2_r[gi]),
        .rd_clr (stat_rd),
        .flag   (flag[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Mode selection
  // ---------------------------------------------------------------------
  logic hw_fail;
  logic app_fail;

  // Hardware group outranks application group
  assign hw_fail  = flag[`PFS_BIT_THERM] | flag[`PFS_BIT_PUMPUV] |
                    flag[`PFS_BIT_SUPLOW];                // see (RULE8)
  assign app_fail = flag[`PFS_BIT_DIMM] | flag[`PFS_BIT_TIMEOUT];

  pfs_pkg::pfs_state_e st_r;
  pfs_pkg::pfs_state_e st_nxt;
  logic [NSW-1:0]      sw_r;
  logic [NSW-1:0]      sw_nxt;
  logic [NSW-1:0]      swreg_r;
  logic [NSW-1:0]      swreg_nxt;
  logic                tmo_seen_r;
  logic                tmo_seen_nxt;
  logic [1:0]          opm_r;
  logic [1:0]          opm_nxt;
  logic                boot_r;
  logic                boot_nxt;
  logic                sw_wr;

  assign sw_wr = reg_wr && (reg_addr == `PFS_OFS_SWITCH);

  // Next state, switch drive and host switch register
  always_comb begin
    st_nxt       = st_r;
    sw_nxt       = sw_r;
    swreg_nxt    = swreg_r;
    tmo_seen_nxt = tmo_seen_r;
    opm_nxt      = opm_r;
    boot_nxt     = 1'b0;
    if (boot_r) begin
      if (!otp_s2_r[NSW+2])
        opm_nxt = `PFS_OPM_CONFIG;                        // see (RULE12)
      else if (otp_s2_r[NSW+1:NSW] == `PFS_OPM_NOCRC)
        opm_nxt = `PFS_OPM_NOCRC;                         // see (RULE11)
      else if (otp_s2_r[NSW+1:NSW] == `PFS_OPM_NORMAL)
        opm_nxt = `PFS_OPM_NORMAL;                        // see (RULE11)
      else
        opm_nxt = `PFS_OPM_CONFIG;
    end
    if (sw_wr)
      swreg_nxt = reg_wdata[NSW-1:0];
    if (!flag[`PFS_BIT_TIMEOUT])
      tmo_seen_nxt = 1'b0;
    case (st_r)
      pfs_pkg::PFS_ST_RUN: begin
        if (sw_wr)
          sw_nxt = reg_wdata[NSW-1:0];
        if (hw_fail) begin
          st_nxt = pfs_pkg::PFS_ST_OPEN;                  // see (RULE10)
          sw_nxt = '0;                                    // see (RULE8)
        end else if (app_fail) begin
          st_nxt = pfs_pkg::PFS_ST_OTP;                   // see (RULE3)
        end
      end
      pfs_pkg::PFS_ST_OPEN: begin
        sw_nxt = '0;                                      // see (RULE8)
        if (!hw_fail) begin
          sw_nxt = sw_wr ? reg_wdata[NSW-1:0] : swreg_r;  // see (RULE9)
          st_nxt = app_fail ? pfs_pkg::PFS_ST_OTP : pfs_pkg::PFS_ST_RUN;
        end
      end
      pfs_pkg::PFS_ST_OTP: begin
        if (sw_wr)
          sw_nxt = reg_wdata[NSW-1:0];                    // see (RULE7)
        if (flag[`PFS_BIT_TIMEOUT] && !tmo_seen_r) begin
          tmo_seen_nxt = 1'b1;
          sw_nxt = otp_s2_r[NSW+2] ? otp_s2_r[NSW-1:0]    // see (RULE4)
                                   : '0;                  // see (RULE5)
        end
        if (hw_fail) begin
          st_nxt = pfs_pkg::PFS_ST_OPEN;                  // see (RULE10)
          sw_nxt = '0;
        end else if (!app_fail) begin
          st_nxt = pfs_pkg::PFS_ST_RUN;                   // see (RULE6)
        end
      end
      default: begin
        st_nxt = pfs_pkg::PFS_ST_RUN;
        sw_nxt = '0;
      end
    endcase
    if (st_nxt == pfs_pkg::PFS_ST_RUN && app_fail)
      st_nxt = pfs_pkg::PFS_ST_OTP;                       // see (RULE1)
  end

  // Register supervisor state
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r       <= pfs_pkg::PFS_ST_RUN;
      sw_r       <= '0;
      swreg_r    <= '0;
      tmo_seen_r <= 1'b0;
      opm_r      <= `PFS_OPM_CONFIG;
      boot_r     <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      sw_r       <= sw_nxt;
      swreg_r    <= swreg_nxt;
      tmo_seen_r <= tmo_seen_nxt;
      opm_r      <= opm_nxt;
      boot_r     <= boot_nxt;
    end
  end

  // ---------------------------------------------------------------------
  // Read data and outputs
  // ---------------------------------------------------------------------
  logic [`PFS_DATA_W-1:0] rdata_r;
  logic [`PFS_DATA_W-1:0] rdata_nxt;

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      rdata_nxt = '0;
      if (reg_addr == `PFS_OFS_SWITCH)
        rdata_nxt[NSW-1:0] = swreg_r;
      else if (reg_addr == `PFS_OFS_STATUS) begin
        rdata_nxt[NF-1:0]            = flag;
        rdata_nxt[`PFS_BIT_FS_OPEN]  = (st_r == pfs_pkg::PFS_ST_OPEN);
        rdata_nxt[`PFS_BIT_FS_OTP]   = (st_r == pfs_pkg::PFS_ST_OTP);
        rdata_nxt[`PFS_OPM_LSB+1 -: 2] = opm_r;
      end
    end
  end

  // Register read data
  always_ff @(posedge mclk) begin
    if (rst)
      rdata_r <= '0;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata     = rdata_r;
  assign switch_on     = sw_r;
  assign op_mode       = opm_r;
  assign failsafe_open = (st_r == pfs_pkg::PFS_ST_OPEN);
  assign failsafe_otp  = (st_r == pfs_pkg::PFS_ST_OTP);

endmodule : pfs_failsafe_ctrl

/* sim/pfs_failsafe_sva.sv */
/* Checker for the fail-safe supervisor ports.
   Assumes it is bound to pfs_failsafe_ctrl on one mclk domain. */
`timescale 1ns/1ps
`include "pfs_defs.svh"
module pfs_failsafe_sva #(
  parameter int NSW = 12
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic        thermal_shutdown_flag,
  input wire logic        pump_cap_undervoltage_flag,
  input wire logic        supply_low_flag,
  input wire logic        dimming_error_flag,
  input wire logic        timeout_in,
  input wire logic        otp_programmed,
  input wire logic [1:0]  otp_mode,
  input wire logic [NSW-1:0] otp_failsafe_sw,
  input wire logic [NSW-1:0] switch_on,
  input wire logic [1:0]  op_mode,
  input wire logic        failsafe_open,
  input wire logic        failsafe_otp
);
  logic [NSW-1:0] shd_r;
  logic [NSW-1:0] shd_nxt;
  wire hw  = thermal_shutdown_flag | pump_cap_undervoltage_flag |
             supply_low_flag;
  wire app = dimming_error_flag | timeout_in;
  wire rds = reg_rd && reg_addr == `PFS_OFS_STATUS;
  wire fs  = failsafe_open | failsafe_otp;
  // Copy of the switch register from observed writes
  always_comb begin
    shd_nxt = shd_r;
    if (reg_wr && reg_addr == `PFS_OFS_SWITCH)
      shd_nxt = reg_wdata[NSW-1:0];
  end
  // Register the copy
  always_ff @(posedge mclk) begin
    shd_r <= rst ? {NSW{1'b0}} : shd_nxt;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_open_off;
    failsafe_open |-> switch_on == {NSW{1'b0}};
  endproperty
  a_open_off: assert property (p_open_off)
    else $error("switch on in open");
  property p_one;
    !(failsafe_open && failsafe_otp);
  endproperty
  a_one: assert property (p_one)
    else $error("two modes at once");
  property p_hw;
    hw[*6] |-> failsafe_open;
  endproperty
  a_hw: assert property (p_hw)
    else $error("no open mode");
  property p_app;
    (app && !hw)[*6] |-> fs;
  endproperty
  a_app: assert property (p_app)
    else $error("no fail-safe");
  property p_boot;
    $fell(rst) |=> op_mode == ((otp_programmed && otp_mode != 2'h3) ?
                               otp_mode : `PFS_OPM_CONFIG);
  endproperty
  a_boot: assert property (p_boot)
    else $error("boot mode");
  property p_sticky;
    fs && !rds && !$past(rds) |=> fs;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("left early");
  property p_restore;
    $fell(failsafe_open) && !failsafe_otp |-> switch_on == shd_r;
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore");
  property p_rd_st;
    rds |=> reg_rdata[8] == $past(failsafe_open) &&
            reg_rdata[9] == $past(failsafe_otp) &&
            reg_rdata[13:12] == $past(op_mode);
  endproperty
  a_rd_st: assert property (p_rd_st)
    else $error("status read");
  property p_unmap;
    reg_rd && reg_addr != `PFS_OFS_SWITCH && !rds |=>
      reg_rdata == 24'h000000;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read");
  c_open: cover property ($fell(failsafe_open));
  c_otp: cover property ($fell(failsafe_otp));
  c_rd: cover property (rds && fs);
endmodule : pfs_failsafe_sva
bind pfs_failsafe_ctrl pfs_failsafe_sva #(.NSW(NSW)) u_sva (.mclk, .rst,
  .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .thermal_shutdown_flag,
  .pump_cap_undervoltage_flag, .supply_low_flag, .dimming_error_flag,
  .timeout_in, .otp_programmed, .otp_mode, .otp_failsafe_sw, .switch_on,
  .op_mode, .failsafe_open, .failsafe_otp);

/* sim/pfs_host_model.sv */
/* Host controller model issuing one-cycle register strobes.
   Assumes callers start each access at any time after reset. */
`timescale 1ns/1ps
module pfs_host_model (
  input  wire logic        mclk,
  input  wire logic [23:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic [7:0]       reg_addr,
  output logic [23:0]      reg_wdata
);
  // Idle bus
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 24'h000000;
  end
  // Write taken at one edge; idle lines then show stale inverse
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // Read; data stands from the edge after the strobe
  task automatic rd(input logic [7:0] a,
                    output logic [23:0] d);
    @(posedge mclk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk) #1;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask : rd
endmodule : pfs_host_model

/* sim/pfs_failsafe_ctrl_tb.sv */
/* Bench for the fail-safe supervisor: boot modes, registers, faults.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module pfs_failsafe_ctrl_tb;
  logic mclk, rst, thr, cuv, slo, dim, tmo, prog, fo, ft, rw, rr;
  logic [1:0] omode, opm;
  logic [11:0] osw, sw;
  logic [7:0] ra;
  logic [23:0] wd, rdat, d;
  int err_count = 0, checked = 0, cyc = 0;
  pfs_failsafe_ctrl dut (.mclk, .rst, .reg_wr(rw), .reg_rd(rr), .reg_addr(ra),
    .reg_wdata(wd), .reg_rdata(rdat), .thermal_shutdown_flag(thr),
    .pump_cap_undervoltage_flag(cuv), .supply_low_flag(slo),
    .dimming_error_flag(dim), .timeout_in(tmo), .otp_programmed(prog),
    .otp_mode(omode), .otp_failsafe_sw(osw), .switch_on(sw), .op_mode(opm),
    .failsafe_open(fo), .failsafe_otp(ft));
  pfs_host_model host (.mclk, .reg_rdata(rdat), .reg_wr(rw), .reg_rd(rr),
    .reg_addr(ra), .reg_wdata(wd));
  // Clock and hang guard
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wt
  task automatic boot(input logic p, input logic [1:0] m);
    wt(1);
    rst = 1'b1;
    prog = p;
    omode = m;
    wt(20);
    rst = 1'b0;
    wt(2);
  endtask : boot
  task automatic pins(input logic [4:0] v, input int n);
    {tmo, dim, slo, cuv, thr} = v;
    wt(n);
  endtask : pins
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, tmo, dim, slo, cuv, thr, prog} = 7'h41;
    omode = 2'h0;
    osw = 12'h5A3;
    for (int m = 0; m < 3; m++) begin
      boot(1'b1, m[1:0]);
      chk("op_mode", m, opm);
    end
    host.wr(8'h00, 24'h000C3C);
    host.rd(8'h00, d);
    chk("sw_reg", 24'h000C3C, d);
    chk("switch", 24'h000C3C, sw);
    host.rd(8'h04, d);
    chk("unmapped", 24'h000000, d);
    $display("test registers done");
    pins(5'h10, 8);
    chk("tmo_otp", 1, ft);
    chk("tmo_sw", osw, sw);
    host.rd(8'h10, d);
    chk("status", 24'h002210, d);
    pins(5'h00, 6);
    chk("sticky", 1, ft);
    host.rd(8'h10, d);
    chk("status2", 24'h002210, d);
    wt(3);
    chk("otp_left", 0, ft);
    chk("sw_kept", osw, sw);
    pins(5'h08, 8);
    chk("dim_otp", 1, ft);
    chk("dim_sw", osw, sw);
    host.wr(8'h00, 24'h000111);
    chk("dim_wr", 24'h000111, sw);
    $display("test app faults done");
    for (int i = 0; i < 3; i++) begin
      pins(5'h18 | (5'h01 << i), 8);
      chk("open", 1, fo);
      chk("sw_off", 0, sw);
      host.wr(8'h00, 24'h000222 + i);
      pins(5'h00, 6);
      host.rd(8'h10, d);
      chk("hw_stat", 24'h002118 | (24'h000001 << i), d);
      wt(3);
      chk("restore", 24'h000222 + i, sw);
      chk("run", 0, {fo, ft});
    end
    $display("test hw faults done");
    boot(1'b0, 2'h1);
    chk("cfg", 0, opm);
    host.wr(8'h00, 24'h000FFF);
    pins(5'h10, 8);
    chk("unzap_sw", 0, sw);
    $display("test unprogrammed done");
    complete_run();
  end
endmodule : pfs_failsafe_ctrl_tb
